// File: logic/pao_consts.vh
// Constants for the pipelined converter output interface
// Contract
// - Each result leaves as a 12-bit parallel word, output bit one the MSB and bit twelve the LSB.
// - A high output-disable input floats all twelve data outputs; low drives them.
// - A high coding-select input inverts only the MSB for two's complement; low is offset binary.
// - Valid data appears six and a half convert-clock cycles after the sampling event.
// - The pipeline advances on both rising and falling convert-clock edges.
// - The quantizer has eleven two-bit stages, two of them completing per convert-clock cycle.
// - Each stage result passes its own delay line, then error correction forms the final word.
// - In offset binary a positive full-scale input gives a word of all ones.
// - Unconnected coding-select and output-disable default low: offset binary, outputs enabled.
`ifndef PAO_CONSTS_VH
`define PAO_CONSTS_VH
`define PAO_WORD_W 12
`define PAO_STAGES 11
`define PAO_STAGE_W 2
`define PAO_HALF_LAT 13
`define PAO_FIFO_W 12
`define PAO_FIFO_D 16
`define PAO_FIFO_AW 4
`define PAO_WORD_RST 12'h000
`define PAO_MSB_POS 11
`endif

// File: logic/pao_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pao_fifo #(
    parameter W = 12,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clock,          // Clock
    input wire sys_rst,        // Async reset, high
    input wire in_valid,       // Write request
    output wire in_ready,      // Room available
    input wire [W-1:0] in_data, // Write data
    output wire out_valid,     // Data available
    input wire out_ready,      // Read accept
    output wire [W-1:0] out_data // Head word
);
    reg [W-1:0] mem_ff [0:D-1];
    reg [AW-1:0] wr_ff;
    reg [AW-1:0] rd_ff;
    reg [AW:0] cnt_ff;
    wire push;
    wire pop;
    integer i;
    localparam [AW:0] FULL_CNT = D;
    assign in_ready = (cnt_ff != FULL_CNT);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ff];
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ff <= {AW{1'b0}};
            rd_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            for (i = 0; i < D; i = i + 1) begin
                mem_ff[i] <= {W{1'b0}};
            end
        end else begin
            if (push) begin
                mem_ff[wr_ff] <= in_data;
                wr_ff <= wr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ff <= rd_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// File: logic/pao_top.v
// Digital output side of a 12-bit pipelined converter
`timescale 1ns/100ps
`include "pao_consts.vh"
module pao_top (
    input wire clock,                 // 100 MHz system clock
    input wire sys_rst,               // Async reset, high
    input wire conv_clk,              // Convert clock pin, sampled
    input wire [21:0] stage_bits,     // Raw two-bit codes, stage 0 in low bits
    input wire out_disable,           // High floats data outputs
    input wire top_bit_invert_sel,    // High selects two's complement
    output wire [11:0] data_out,      // Bit 11 is out_bit_msb, bit 0 out_bit_lsb
    output wire [11:0] data_oe_n,     // Low while driving
    output reg word_strobe_ff,        // One pulse per new word
    output wire fifo_valid,           // Captured word available
    input wire fifo_ready,            // Downstream accepts word
    output wire [11:0] fifo_data      // Captured word
);
    // Pin inputs: three stages, change counts when stages two and three agree
    reg [2:0] clk_sync_ff;
    reg [2:0] dis_sync_ff;
    reg [2:0] inv_sync_ff;
    reg clk_lvl_ff;
    reg dis_lvl_ff;
    reg inv_lvl_ff;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clk_sync_ff <= 3'h0;
            dis_sync_ff <= 3'h0;
            inv_sync_ff <= 3'h0;
            clk_lvl_ff <= 1'b0;
            dis_lvl_ff <= 1'b0; // Defaults as if the pins float low
            inv_lvl_ff <= 1'b0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[1:0], conv_clk};
            dis_sync_ff <= {dis_sync_ff[1:0], out_disable};
            inv_sync_ff <= {inv_sync_ff[1:0], top_bit_invert_sel};
            if (clk_sync_ff[1] == clk_sync_ff[2]) begin
                clk_lvl_ff <= clk_sync_ff[2];
            end
            if (dis_sync_ff[1] == dis_sync_ff[2]) begin
                dis_lvl_ff <= dis_sync_ff[2];
            end
            if (inv_sync_ff[1] == inv_sync_ff[2]) begin
                inv_lvl_ff <= inv_sync_ff[2];
            end
        end
    end

    reg clk_prev_ff;
    wire half_edge;
    wire rise_edge;
    assign half_edge = clk_lvl_ff ^ clk_prev_ff; // Either convert-clock edge
    assign rise_edge = clk_lvl_ff & ~clk_prev_ff;

    // Each stage resolves on one half-cycle; stage k is delayed so all align
    // Delay line for stage k is (STAGES-k) half-cycles long.
    reg [1:0] dly_ff [0:`PAO_STAGES-1][0:`PAO_STAGES-1];
    genvar k;
    genvar j;
    generate
        for (k = 0; k < `PAO_STAGES; k = k + 1) begin : g_stage
            for (j = 0; j < `PAO_STAGES; j = j + 1) begin : g_tap
                always @(posedge clock or posedge sys_rst) begin
                    if (sys_rst) begin
                        dly_ff[k][j] <= 2'h0;
                    end else if (half_edge) begin
                        if (j == 0) begin
                            dly_ff[k][j] <= stage_bits[2*k+1:2*k];
                        end else begin
                            dly_ff[k][j] <= dly_ff[k][j-1];
                        end
                    end
                end
            end
        end
    endgenerate

    // Error correction: stages overlap by one redundant bit, sum with 1-bit weight steps
    reg [12:0] corr_sum;
    integer s;
    always @* begin
        corr_sum = 13'h0000;
        for (s = 0; s < `PAO_STAGES; s = s + 1) begin
            corr_sum = corr_sum + ({11'h000, dly_ff[s][`PAO_STAGES-1-s]} << (`PAO_STAGES-1-s));
        end
    end
    wire [11:0] corr_word;
    // Overflow saturates so positive full scale reads all ones
    assign corr_word = corr_sum[12] ? 12'hfff : corr_sum[11:0];

    // Edge detector reset matches the idle-low pin, so no false edge after reset
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clk_prev_ff <= 1'b0;
        end else begin
            clk_prev_ff <= clk_lvl_ff;
        end
    end

    wire fall_edge;
    assign fall_edge = half_edge & ~rise_edge;

    // Extra half-cycle delay brings total latency to 6.5 convert cycles
    // Fill state holds the outputs until the pipeline has carried a full word
    localparam ST_FILL = 1'b0;
    localparam ST_RUN = 1'b1;
    reg state_ff;
    reg nxt_state;
    reg [3:0] half_cnt_ff;
    reg [3:0] nxt_half_cnt;
    reg [11:0] lat_word_ff;
    reg [11:0] nxt_lat_word;
    reg [11:0] out_word_ff;
    reg [11:0] nxt_out_word;
    reg nxt_word_strobe;
    wire word_push;

    always @* begin
        nxt_state = state_ff;
        nxt_half_cnt = half_cnt_ff;
        nxt_lat_word = lat_word_ff;
        nxt_out_word = out_word_ff;
        nxt_word_strobe = 1'b0;
        if (half_edge) begin
            nxt_lat_word = corr_word;
            if (half_cnt_ff != `PAO_HALF_LAT) begin
                nxt_half_cnt = half_cnt_ff + 4'h1;
            end
        end
        case (state_ff)
            ST_FILL: begin
                // First update once twelve half-edges have passed
                if (fall_edge && half_cnt_ff >= (`PAO_HALF_LAT - 1)) begin
                    nxt_state = ST_RUN;
                    nxt_out_word[`PAO_MSB_POS] = lat_word_ff[`PAO_MSB_POS] ^ inv_lvl_ff;
                    nxt_out_word[`PAO_MSB_POS-1:0] = lat_word_ff[`PAO_MSB_POS-1:0];
                    nxt_word_strobe = 1'b1;
                end
            end
            ST_RUN: begin
                // Data changes on falling edge; capture on rise
                if (fall_edge) begin
                    nxt_out_word[`PAO_MSB_POS] = lat_word_ff[`PAO_MSB_POS] ^ inv_lvl_ff;
                    nxt_out_word[`PAO_MSB_POS-1:0] = lat_word_ff[`PAO_MSB_POS-1:0];
                    nxt_word_strobe = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_FILL;
            end
        endcase
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_FILL;
            half_cnt_ff <= 4'h0;
            lat_word_ff <= `PAO_WORD_RST;
            out_word_ff <= `PAO_WORD_RST;
            word_strobe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            half_cnt_ff <= nxt_half_cnt;
            lat_word_ff <= nxt_lat_word;
            out_word_ff <= nxt_out_word;
            word_strobe_ff <= nxt_word_strobe;
        end
    end

    assign word_push = word_strobe_ff & (state_ff == ST_RUN);

    assign data_out = out_word_ff;
    // Enable is taken from the pin level; toggling mid-stream is the user's concern
    assign data_oe_n = {`PAO_WORD_W{dis_lvl_ff}};

    // Words are queued so a slow consumer loses none while it has room
    pao_fifo #(
        .W(`PAO_FIFO_W),
        .D(`PAO_FIFO_D),
        .AW(`PAO_FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(word_push),
        .in_ready(),
        .in_data(out_word_ff),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );
endmodule

// File: tb/pao_top_properties.sv
// Port checker for the converter output interface
`timescale 1ns/100ps
module pao_top_chk (
    input wire clock, // Clock
    input wire sys_rst, // Reset
    input wire conv_clk, // Convert pin
    input wire out_disable, // Float pin
    input wire [11:0] data_out, // Word
    input wire [11:0] data_oe_n, // Enables
    input wire word_strobe_ff, // Update
    input wire fifo_valid, // Head valid
    input wire fifo_ready, // Pop
    input wire [11:0] fifo_data // Head
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_off_held;
        out_disable [*6];
    endsequence
    sequence s_on_held;
        !out_disable [*6];
    endsequence
    property p_oe_same;
        data_oe_n == {12{data_oe_n[0]}};
    endproperty
    a_oe_same: assert property (p_oe_same) else $error("enables split");
    property p_oe_off;
        s_off_held |=> data_oe_n == 12'hfff;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("outputs not floated");
    property p_oe_on;
        s_on_held |=> data_oe_n == 12'h000;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
    property p_upd_strobe;
        $changed(data_out) |-> word_strobe_ff;
    endproperty
    a_upd_strobe: assert property (p_upd_strobe) else $error("silent update");
    property p_strobe_pulse;
        word_strobe_ff |=> !word_strobe_ff [*4];
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    property p_strobe_src;
        word_strobe_ff |-> !$past(conv_clk, 4) && $past(conv_clk, 8);
    endproperty
    a_strobe_src: assert property (p_strobe_src) else $error("strobe without fall");
    property p_push_src;
        $rose(fifo_valid) |-> $past(word_strobe_ff);
    endproperty
    a_push_src: assert property (p_push_src) else $error("push without word");
    property p_head_hold;
        fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data);
    endproperty
    a_head_hold: assert property (p_head_hold) else $error("head lost");
endmodule
bind pao_top pao_top_chk i_chk (.clock(clock), .sys_rst(sys_rst), .conv_clk(conv_clk),
    .out_disable(out_disable), .data_out(data_out), .data_oe_n(data_oe_n),
    .word_strobe_ff(word_strobe_ff), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
    .fifo_data(fifo_data));

// File: tb/pao_capture.sv
// Host capture model popping words with random stalls
`timescale 1ns/100ps
module pao_capture (
    input wire clock, // Clock
    input wire sys_rst, // Reset
    input wire fifo_valid, // Head valid
    input wire [11:0] fifo_data, // Head
    output logic fifo_ready, // Pop
    output logic [11:0] last_word_ff // Latest word
);
    integer seed = 51383;
    logic [2:0] drop_cnt_ff;
    // One word per pop, taken away from the update edge
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_ready <= 1'b0;
            last_word_ff <= 12'h000;
            drop_cnt_ff <= 3'h0;
        end else begin
            if (fifo_valid && fifo_ready) begin
                if (drop_cnt_ff != 3'h7) begin
                    drop_cnt_ff <= drop_cnt_ff + 3'h1; // Fill words dropped
                end else begin
                    last_word_ff <= fifo_data;
                end
            end
            fifo_ready <= ($random(seed) % 4) != 0;
        end
    end
endmodule

// File: tb/pao_top_tb_top.sv
// Randomised bench for the converter output interface
`timescale 1ns/100ps
module pao_top_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic conv_clk = 1'b0;
    logic [21:0] stage_bits = 22'h000000;
    logic out_disable = 1'b0;
    logic top_bit_invert_sel = 1'b0;
    wire [11:0] data_out, data_oe_n, fifo_data, last_word_ff;
    wire word_strobe_ff, fifo_valid, fifo_ready;
    integer seed = 51383;
    integer failures = 0;
    integer samples_checked = 0;
    integer n, r;
    pao_top i_pao_top (.clock(clock), .sys_rst(sys_rst), .conv_clk(conv_clk),
        .stage_bits(stage_bits), .out_disable(out_disable),
        .top_bit_invert_sel(top_bit_invert_sel), .data_out(data_out), .data_oe_n(data_oe_n),
        .word_strobe_ff(word_strobe_ff), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
        .fifo_data(fifo_data));
    pao_capture i_pao_capture (.clock(clock), .sys_rst(sys_rst), .fifo_valid(fifo_valid),
        .fifo_data(fifo_data), .fifo_ready(fifo_ready), .last_word_ff(last_word_ff));
    always #5 clock = ~clock;
    // Even duty, ten cycles a level, well above the sync span
    always begin
        repeat (10) @(posedge clock);
        #1 conv_clk = ~conv_clk;
    end
    function automatic [11:0] exp_word(input [21:0] s, input sel);
        integer k, sum;
        sum = 0;
        for (k = 0; k < 11; k = k + 1) begin
            sum = sum + (s[2*k +: 2] << (10 - k));
        end
        if (sum > 4095) sum = 4095;
        exp_word = sum[11:0] ^ {sel, 11'h000};
    endfunction
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input [11:0] got, input [11:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_words(input integer cnt);
        integer t;
        t = 0;
        while (cnt > 0 && t < 2000) begin
            @(negedge clock);
            t = t + 1;
            if (word_strobe_ff === 1'b1) cnt = cnt - 1;
        end
        if (cnt > 0) begin
            failures = failures + 1;
            end_of_test;
        end
        @(posedge clock);
        #1;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        #1 sys_rst = 1'b0;
        for (n = 0; n < 12; n = n + 1) begin
            r = $random(seed);
            stage_bits = (n == 0) ? 22'h3fffff : (n == 1) ? 22'h000000 : r[21:0];
            top_bit_invert_sel = n[0];
            wait_words(10);
            check(data_out, exp_word(stage_bits, n[0]));
            check(last_word_ff, exp_word(stage_bits, n[0]));
            $display("word test %0d done", n);
        end
        out_disable = 1'b1; // Held static for a whole test phase
        wait_words(2);
        check(data_oe_n, 12'hfff);
        out_disable = 1'b0;
        wait_words(2);
        check(data_oe_n, 12'h000);
        $display("float test done");
        end_of_test;
    end
endmodule
